/* hw/nv_memory_access_port.sv */
// non-volatile memory access port: latches, byte-wide and serial engines
// Function
// - serial memory over clock and data only
// - byte-wide: 8-bit data, 16-bit address, strobes
// - host and local control registers both reach memory
// - rom window read is four byte reads
// - rom window writes never alter memory
// - 8-bit address/data latch at bits 23:16
// - 3-bit enable/decode latch at bits 31:29
// - target latches change only while enable set or on C0h
// - bit 31 reads busy during memory access
// - staged byte commits on next enable/decode change while enable set
// - 80h selects low address latch
// - A0h commits low, selects high latch
// - 00h clears enable, commits selected latch
// - C0h commits data, starts memory write
// - E0h starts read, byte returns in latch
// - latches at byte offsets 3Eh and 3Fh
// - serial clock is clock divided by 512
// - latched addresses kept, never incremented
`timescale 1ns/10ps
`default_nettype none
module nv_memory_access_port
    import nv_access_pkg::*;
#(
    parameter int SCL_DIV = nv_access_pkg::NV_SCL_DIV,
    parameter logic [6:0] DEV_SEL = nv_access_pkg::NV_DEV_SEL
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // strap: serial memory fitted
    input wire logic serial_mode,
    // host side control/status register
    input wire logic host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    // local side control/status register
    input wire logic local_wr,
    input wire logic [7:0] local_addr,
    input wire logic [3:0] local_be,
    input wire logic [31:0] local_wdata,
    output logic [31:0] local_rdata,
    // expansion rom window, read only
    input wire logic rom_req,
    input wire logic [15:0] rom_addr,
    output logic rom_ack,
    output logic [31:0] rom_data,
    // byte-wide memory
    output logic [15:0] parallel_mem_address_bus,
    output logic [7:0] parallel_mem_data_bus_o,
    input wire logic [7:0] parallel_mem_data_bus_i,
    output logic parallel_mem_data_bus_oe,
    output logic mem_read_strobe_n,
    output logic mem_write_strobe_n,
    // serial memory
    output logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import nv_access_pkg::*;
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int CW = $clog2(SCL_DIV); // divider counter width
    localparam int QTR = SCL_DIV / 4; // quarter of a serial bit
    typedef struct packed {
        nv_state_t st; // engine state
        logic [7:0] stage; // staged address/data byte
        logic [2:0] ctrl; // enable and decode bits
        logic [7:0] alo; // low address latch
        logic [7:0] ahi; // high address latch
        logic [7:0] dat; // data latch
        logic busy; // memory access running
        logic op_rd; // current access is a read
        logic rom_act; // rom word fetch running
        logic rom_pend; // rom word fetch waiting
        logic [13:0] rom_a; // rom word address
        logic [1:0] rom_idx; // byte within rom word
        logic [31:0] rom_buf; // bytes gathered so far
        logic rom_ack; // rom word done pulse
        logic [31:0] rom_data; // rom word returned
        logic [31:0] rdata; // register read-back
        logic [CW-1:0] cnt; // bit or cycle counter
        logic [3:0] bitn; // bit within serial byte
        logic [2:0] bytn; // byte slot within frame
        logic [7:0] shf; // serial transmit shifter
        logic [7:0] rx; // serial receive shifter
        logic [15:0] pa; // byte-wide address out
        logic [7:0] pq; // byte-wide data out
        logic poe; // byte-wide data enable
        logic prd; // read strobe, active high here
        logic pwr; // write strobe, active high here
        logic scl_lo; // serial clock held low
        logic sda_lo; // serial data pulled low
        logic [2:0] sy_sda; // serial data synchroniser
        logic sda_f; // filtered serial data
        logic [7:0] sy0; // data bus sync stage 1
        logic [7:0] sy1; // data bus sync stage 2
        logic [7:0] sy2; // data bus sync stage 3
        logic [7:0] pq_f; // filtered data bus
    } state_t;
    localparam state_t RST_VAL = '{st: ST_IDLE, default: '0};
    state_t q; // registered state
    state_t d; // next state
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // register word hit for a port
    function automatic logic reg_hit(input logic wr, input logic [7:0] a);
        reg_hit = wr && (a[7:2] == NV_OFS_WORD[7:2]);
    endfunction
    // quarter of the serial bit period
    function automatic logic [1:0] phase_of(input logic [CW-1:0] c);
        phase_of = c[CW-1 -: 2];
    endfunction
    // byte sent in a serial frame slot
    function automatic logic [7:0] tx_byte(input logic [2:0] slot, input state_t s);
        case (slot)
            NV_B_DEVW: tx_byte = {DEV_SEL, 1'b0};
            NV_B_AHI: tx_byte = s.rom_act ? s.rom_a[13:6] : s.ahi; // high byte of rom address
            NV_B_ALO: tx_byte = s.rom_act ? {s.rom_a[5:0], s.rom_idx} : s.alo;
            default: tx_byte = s.op_rd ? {DEV_SEL, 1'b1} : s.dat;
        endcase
    endfunction
    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic acc, go, rd, fin, rxb; // strobes of this cycle
        logic [3:0] be; // byte enables taken
        logic [31:0] wd; // write word taken
        logic [7:0] stg, fbyte; // staged byte, finished byte
        logic [2:0] nc; // new enable/decode bits
        logic [1:0] ph; // serial quarter
        acc = 1'b0;
        be = '0;
        wd = '0;
        stg = q.stage;
        nc = q.ctrl;
        go = 1'b0;
        rd = 1'b0;
        fin = 1'b0;
        fbyte = '0;
        rxb = q.op_rd && (q.bytn == NV_B_RX);
        ph = phase_of(q.cnt);
        d = q;
        d.rom_ack = 1'b0;
        // pin synchronisers; a change counts once stages 2 and 3 agree
        d.sy_sda = {q.sy_sda[1:0], sda_i};
        if (q.sy_sda[1] == q.sy_sda[2]) begin
            d.sda_f = q.sy_sda[2];
        end
        d.sy0 = parallel_mem_data_bus_i;
        d.sy1 = q.sy0;
        d.sy2 = q.sy1;
        d.pq_f = (~(q.sy1 ^ q.sy2) & q.sy2) | ((q.sy1 ^ q.sy2) & q.pq_f);
        // host port wins a same-cycle clash with the local port
        if (reg_hit(host_wr, host_addr)) begin
            acc = 1'b1;
            be = host_be;
            wd = host_wdata;
        end else if (reg_hit(local_wr, local_addr)) begin
            acc = 1'b1;
            be = local_be;
            wd = local_wdata;
        end
        // latch writes are ignored while an access runs
        if (acc && !q.busy) begin
            if (be[NV_LANE_DATA]) begin
                stg = wd[NV_DATA_LSB +: 8];
                d.stage = stg;
            end
            if (be[NV_LANE_CTRL]) begin
                nc = wd[NV_CTRL_LSB +: 3];
                // commit only on an enable/decode change with the door open
                if (q.ctrl[2] && (nc != q.ctrl)) begin
                    case (q.ctrl[1:0])
                        NV_DEC_LOW: d.alo = stg;
                        NV_DEC_HIGH: d.ahi = stg;
                        NV_DEC_DATA: d.dat = stg;
                        default: ;
                    endcase
                end
                d.dat = (nc == NV_CMD_WRITE) ? stg : d.dat; // write takes staged byte
                d.ctrl = nc;
                go = (nc == NV_CMD_WRITE) || (nc == NV_CMD_READ);
                rd = (nc == NV_CMD_READ);
            end
        end
        // rom window: only reads exist, so memory is never written here
        if (rom_req && !q.rom_pend && !q.rom_act) begin
            d.rom_pend = 1'b1;
            d.rom_a = rom_addr[15:2];
        end
        // engine
        case (q.st)
            ST_IDLE: begin
                d.scl_lo = 1'b0;
                d.sda_lo = 1'b0;
                d.prd = 1'b0;
                d.pwr = 1'b0;
                d.poe = 1'b0;
                if (go || q.rom_pend) begin
                    d.busy = 1'b1;
                    d.op_rd = go ? rd : 1'b1;
                    d.rom_act = !go;
                    d.rom_pend = go ? d.rom_pend : 1'b0;
                    d.rom_idx = '0;
                    d.cnt = '0;
                    d.bytn = NV_B_DEVW;
                    d.st = serial_mode ? ST_START : ST_PAR;
                end
            end
            ST_PAR: begin
                // address first, strobe for six cycles, one to recover
                d.cnt = q.cnt + 1'b1;
                d.pa = q.rom_act ? {q.rom_a, q.rom_idx} : {q.ahi, q.alo};
                d.pq = q.dat;
                d.poe = !q.op_rd;
                d.prd = q.op_rd && (q.cnt >= CW'(NV_PAR_SETUP))
                    && (q.cnt < CW'(NV_PAR_SETUP + NV_PAR_STROBE));
                d.pwr = !q.op_rd && (q.cnt >= CW'(NV_PAR_SETUP))
                    && (q.cnt < CW'(NV_PAR_SETUP + NV_PAR_STROBE));
                if (q.cnt == CW'(NV_PAR_CYCLE - 1)) begin
                    fin = 1'b1;
                    fbyte = q.pq_f;
                end
            end
            ST_START: begin
                // clock high, then data falls while clock is high
                d.cnt = q.cnt + 1'b1;
                d.scl_lo = (ph == 2'h0) || (ph == 2'h3);
                d.sda_lo = ph[1];
                if (q.cnt == CW'(SCL_DIV - 1)) begin
                    d.st = ST_BIT;
                    d.bitn = '0;
                    d.shf = tx_byte(q.bytn, q);
                end
            end
            ST_BIT: begin
                // data moves in quarter 0, clock high in quarters 1 and 2
                d.cnt = q.cnt + 1'b1;
                d.scl_lo = (ph == 2'h0) || (ph == 2'h3);
                d.sda_lo = (q.bitn < NV_ACK_BIT) && !rxb && !q.shf[7];
                if (rxb && (q.bitn < NV_ACK_BIT) && (q.cnt == CW'(2 * QTR))) begin
                    d.rx = {q.rx[6:0], q.sda_f};
                end
                if (q.cnt == CW'(SCL_DIV - 1)) begin
                    if (q.bitn < NV_ACK_BIT) begin
                        d.bitn = q.bitn + 1'b1;
                        d.shf = {q.shf[6:0], 1'b0};
                    end else if (q.op_rd && (q.bytn == NV_B_ALO)) begin
                        d.bytn = NV_B_LAST_TX; // repeated start for the read
                        d.st = ST_START;
                    end else if (q.bytn == (q.op_rd ? NV_B_RX : NV_B_LAST_TX)) begin
                        d.st = ST_STOP;
                    end else begin
                        d.bytn = q.bytn + 1'b1;
                        d.bitn = '0;
                        d.shf = tx_byte(q.bytn + 1'b1, q);
                    end
                end
            end
            ST_STOP: begin
                // data rises while the clock is high
                d.cnt = q.cnt + 1'b1;
                d.scl_lo = (ph == 2'h0);
                d.sda_lo = !ph[1];
                if (q.cnt == CW'(SCL_DIV - 1)) begin
                    fin = 1'b1;
                    fbyte = q.rx;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        // end of one byte access
        if (fin) begin
            d.cnt = '0;
            d.bytn = NV_B_DEVW;
            d.st = ST_IDLE;
            d.busy = 1'b0;
            if (q.rom_act) begin
                d.rom_buf[q.rom_idx * 8 +: 8] = fbyte;
                if (q.rom_idx == 2'(NV_ROM_BYTES - 1)) begin
                    d.rom_data = {fbyte, q.rom_buf[23:0]};
                    d.rom_ack = 1'b1;
                    d.rom_act = 1'b0;
                end else begin
                    d.rom_idx = q.rom_idx + 1'b1;
                    d.busy = 1'b1;
                    d.st = serial_mode ? ST_START : ST_PAR;
                end
            end else if (q.op_rd) begin
                d.stage = fbyte;
            end
        end
        // read-back word: busy, decode and address/data latch
        d.rdata = '0;
        d.rdata[NV_BUSY_BIT] = d.busy;
        d.rdata[NV_CTRL_LSB +: 2] = d.ctrl[1:0];
        d.rdata[NV_DATA_LSB +: 8] = d.stage;
    end
    // ----------------------------------------------------------------
    // state register, frozen while the clock enable is low
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= RST_VAL;
        end else if (clk_en) begin
            q <= d;
        end
    end
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // both requesters see the same latches
    assign host_rdata = q.rdata;
    assign local_rdata = q.rdata;
    assign rom_ack = q.rom_ack;
    assign rom_data = q.rom_data;
    assign parallel_mem_address_bus = q.pa;
    assign parallel_mem_data_bus_o = q.pq;
    assign parallel_mem_data_bus_oe = q.poe;
    assign mem_read_strobe_n = !q.prd;
    assign mem_write_strobe_n = !q.pwr;
    // serial data is open drain: only ever pulled low
    assign scl = !q.scl_lo;
    assign sda_o = 1'b0;
    assign sda_oe = q.sda_lo;
endmodule // nv_memory_access_port
`default_nettype wire

/* hw/nv_access_pkg.sv */
// constants, codes and states for the non-volatile memory access port
package nv_access_pkg;
    // ----------------------------------------------------------------
    // register map (operation register space)
    // ----------------------------------------------------------------
    localparam logic [7:0] NV_OFS_WORD = 8'h3C; // dword holding both latches
    localparam logic [7:0] NV_OFS_ADDR_DATA = 8'h3E; // address/data latch byte
    localparam logic [7:0] NV_OFS_ACCESS_CTRL = 8'h3F; // access-control latch byte
    localparam int NV_LANE_DATA = 2; // byte lane of the address/data latch
    localparam int NV_LANE_CTRL = 3; // byte lane of the access-control latch
    localparam int NV_DATA_LSB = 16; // address/data latch at bits 23:16
    localparam int NV_CTRL_LSB = 29; // access-control latch at bits 31:29
    localparam int NV_BUSY_BIT = 31; // enable on write, busy on read
    // ----------------------------------------------------------------
    // decode values of bits 30:29 and full commands
    // ----------------------------------------------------------------
    localparam logic [1:0] NV_DEC_LOW = 2'h0; // low address latch
    localparam logic [1:0] NV_DEC_HIGH = 2'h1; // high address latch
    localparam logic [1:0] NV_DEC_DATA = 2'h2; // data latch, write
    localparam logic [2:0] NV_CMD_WRITE = 3'h6; // C0h on the control byte
    localparam logic [2:0] NV_CMD_READ = 3'h7; // E0h on the control byte
    // ----------------------------------------------------------------
    // timing, in clock cycles
    // ----------------------------------------------------------------
    localparam int NV_SCL_DIV = 512; // serial clock divider
    localparam int NV_PAR_SETUP = 1; // address valid to strobe active
    localparam int NV_PAR_STROBE = 6; // strobe pulse width
    localparam int NV_PAR_CYCLE = 8; // whole byte-wide cycle
    localparam int NV_ROM_BYTES = 4; // bytes per expansion rom word
    // ----------------------------------------------------------------
    // serial frame byte slots
    // ----------------------------------------------------------------
    localparam logic [2:0] NV_B_DEVW = 3'h0; // device select, write
    localparam logic [2:0] NV_B_AHI = 3'h1; // high address
    localparam logic [2:0] NV_B_ALO = 3'h2; // low address
    localparam logic [2:0] NV_B_LAST_TX = 3'h3; // data (write) or device read
    localparam logic [2:0] NV_B_RX = 3'h4; // received data byte
    localparam logic [3:0] NV_ACK_BIT = 4'h8; // ninth bit of a byte
    localparam logic [6:0] NV_DEV_SEL = 7'h50; // serial device select code
    // ----------------------------------------------------------------
    // engine states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PAR = 5'b00010,
        ST_START = 5'b00100,
        ST_BIT = 5'b01000,
        ST_STOP = 5'b10000
    } nv_state_t;
endpackage

/* tb/nv_port_chk.sv */
// concurrent checks on the non-volatile memory access port pins
`timescale 1ns/10ps
`default_nettype none
module nv_port_chk
    import nv_access_pkg::*;
#(
    parameter int SCL_DIV = 512
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // strap and host requests
    input wire logic serial_mode,
    input wire logic host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    input wire logic [31:0] host_rdata,
    input wire logic [31:0] local_rdata,
    // rom window
    input wire logic rom_req,
    input wire logic rom_ack,
    // memory pins
    input wire logic [15:0] parallel_mem_address_bus,
    input wire logic parallel_mem_data_bus_oe,
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic scl,
    input wire logic sda_oe
);
    import nv_access_pkg::*;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic cmd_wr; // write command taken while idle
    assign cmd_wr = host_wr && host_addr[7:2] == NV_OFS_WORD[7:2] && host_be[3]
        && !host_rdata[31] && host_wdata[31:29] == NV_CMD_WRITE
        && host_rdata[31:29] != NV_CMD_WRITE;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    chk_busy_on_write: assert property (cmd_wr |=> host_rdata[31])
        else $error("busy not raised by write command");
    chk_busy_clears: assert property (!serial_mode && $rose(host_rdata[31]) |->
        ##[1:48] !host_rdata[31]) else $error("busy held too long");
    chk_busy_serial: assert property (serial_mode && $rose(host_rdata[31]) |->
        ##[1:1000] !host_rdata[31]) else $error("serial access never ends");
    chk_par_quiet: assert property (serial_mode |-> mem_read_strobe_n
        && mem_write_strobe_n && !parallel_mem_data_bus_oe)
        else $error("byte-wide pins active in serial mode");
    chk_rd_pulse: assert property ($fell(mem_read_strobe_n) |->
        !mem_read_strobe_n [*6] ##1 mem_read_strobe_n) else $error("read strobe width");
    chk_wr_pulse: assert property ($fell(mem_write_strobe_n) |->
        !mem_write_strobe_n [*6] ##1 mem_write_strobe_n) else $error("write strobe width");
    chk_wr_drive: assert property (!mem_write_strobe_n |-> parallel_mem_data_bus_oe
        && $stable(parallel_mem_address_bus)) else $error("write without driven bus");
    chk_rd_release: assert property (!mem_read_strobe_n |-> !parallel_mem_data_bus_oe
        && mem_write_strobe_n && $stable(parallel_mem_address_bus))
        else $error("read with bus driven");
    chk_no_rom_write: assert property (!mem_write_strobe_n |->
        host_rdata[31:29] == NV_CMD_WRITE) else $error("write strobe outside write command");
    chk_rom_pulse: assert property (rom_ack |=> !rom_ack) else $error("rom ack not a pulse");
    chk_rom_four: assert property (rom_req && !host_rdata[31] && !host_wr |->
        ##[30:60] rom_ack) else $error("rom fetch length");
    chk_views_agree: assert property (host_rdata == local_rdata) else $error("views differ");
    chk_serial_idle: assert property (!serial_mode |-> scl && !sda_oe)
        else $error("serial pins active in byte-wide mode");
endmodule // nv_port_chk
`default_nettype wire

/* tb/nv_bytewide_mem.sv */
// byte-wide non-volatile memory model facing the access port
`timescale 1ns/10ps
`default_nettype none
module nv_bytewide_mem (
    // memory pins
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic rd_n,
    input wire logic wr_n
);
    logic [7:0] mem [0:65535]; // storage
    logic [7:0] last; // last byte read out under the read strobe
    // known pattern so untouched bytes can be predicted
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
        end
        last = 8'h00;
    end
    // byte lands on the rising write strobe
    always @(posedge wr_n) begin
        mem[addr] = wdata;
    end
    // output enabled only under the read strobe; else the last byte read, inverted
    always @(rd_n or addr) begin
        if (!rd_n) begin
            rdata = mem[addr];
            last = rdata;
        end else begin
            rdata = ~last;
        end
    end
endmodule // nv_bytewide_mem
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the non-volatile memory access port
`timescale 1ns/10ps
`default_nettype none
module tb;
    import nv_access_pkg::*;
    logic mclk, rst, clk_en, serial_mode, side; // clock, reset, straps, requester
    logic host_wr, local_wr, rom_req, rom_ack, poe, rd_n, wr_n, scl, sda_o, sda_oe;
    logic [7:0] host_addr, local_addr, pdo, pdi;
    logic [3:0] host_be, local_be;
    logic [31:0] host_wdata, local_wdata, host_rdata, local_rdata, rom_data, rd_now;
    logic [15:0] rom_addr, pa;
    logic [7:0] exp_mem [0:65535]; // expected memory contents
    int errors, cmp_count, cycles;
    assign rd_now = side ? local_rdata : host_rdata;
    nv_memory_access_port #(.SCL_DIV(8)) u_nv_memory_access_port (.mclk(mclk), .rst(rst),
        .clk_en(clk_en), .serial_mode(serial_mode), .host_wr(host_wr), .host_addr(host_addr),
        .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .local_wr(local_wr), .local_addr(local_addr), .local_be(local_be),
        .local_wdata(local_wdata), .local_rdata(local_rdata), .rom_req(rom_req),
        .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_data(rom_data),
        .parallel_mem_address_bus(pa), .parallel_mem_data_bus_o(pdo),
        .parallel_mem_data_bus_i(pdi), .parallel_mem_data_bus_oe(poe),
        .mem_read_strobe_n(rd_n), .mem_write_strobe_n(wr_n), .scl(scl),
        .sda_i(!sda_oe), .sda_o(sda_o), .sda_oe(sda_oe));
    nv_bytewide_mem u_nv_bytewide_mem (.addr(pa), .wdata(pdo), .rdata(pdi), .rd_n(rd_n),
        .wr_n(wr_n));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one register write, launched and dropped on rising edges
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        host_wr <= !side;
        local_wr <= side;
        host_addr <= a;
        local_addr <= a;
        host_be <= be;
        local_be <= be;
        host_wdata <= d;
        local_wdata <= d;
        @(posedge mclk);
        host_wr <= 1'b0;
        local_wr <= 1'b0;
    endtask
    task automatic ctl(input logic [7:0] c);
        wr(NV_OFS_WORD, 4'h8, {c, 24'h0});
    endtask
    task automatic dat(input logic [7:0] b);
        wr(NV_OFS_WORD, 4'h4, {8'h0, b, 16'h0});
    endtask
    // wait for busy to drop, bounded
    task automatic poll();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (rd_now[31] !== 1'b0 && n < 600);
        check(rd_now[31], 0);
    endtask
    // full latch sequence for one byte write or read
    task automatic nv_op(input logic [15:0] a, input logic [7:0] d, input logic wr_op);
        poll();
        ctl(8'h80);
        dat(~a[7:0]);
        dat(a[7:0]);
        ctl(8'hA0);
        dat(a[15:8]);
        if (wr_op) begin
            ctl(8'h00);
            dat(d);
            ctl(8'hC0);
            dat(8'hEE); // refused while busy
            poll();
            check(rd_now[23:16], d);
            exp_mem[a] = d;
        end else begin
            ctl(8'hE0);
            poll();
            check(rd_now[23:16], exp_mem[a]);
        end
    endtask
    // repeat a read with enable closed: latches must hold
    task automatic reread(input logic [15:0] a);
        ctl(8'h00);
        dat(8'h3C);
        ctl(8'hE0);
        poll();
        check(rd_now[23:16], exp_mem[a]);
    endtask
    task automatic rom_rd(input logic [15:0] a);
        int n;
        poll();
        @(posedge mclk);
        rom_req <= 1'b1;
        rom_addr <= a;
        @(posedge mclk);
        rom_req <= 1'b0;
        n = 0;
        #1;
        while (rom_ack !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(rom_ack, 1);
        for (int k = 0; k < NV_ROM_BYTES; k++) begin
            check(rom_data[8*k+:8], exp_mem[{a[15:2], 2'(k)}]);
        end
    endtask
    // ----------------------------------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        logic [15:0] a;
        logic [7:0] d;
        {rst, clk_en, serial_mode, side, host_wr, local_wr, rom_req} = 7'b1100000;
        {host_addr, local_addr, host_be, local_be, host_wdata, local_wdata} = '0;
        rom_addr = 16'h0;
        {errors, cmp_count, cycles} = '0;
        for (int i = 0; i < 65536; i++) exp_mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
        void'($urandom(32'h18C4453A));
        repeat (16) @(posedge mclk);
        check(host_rdata, 0);
        check({rom_ack, rd_n, wr_n, poe}, 4'h6);
        @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom());
            d = 8'($urandom());
            side = 1'($urandom());
            nv_op(a, d, 1'b1);
            side = ~side;
            nv_op(a, 8'h00, 1'b0);
            reread(a);
            nv_op(16'($urandom()), 8'h00, 1'b0);
            rom_rd(i[0] ? a : 16'($urandom()));
        end
        // serial mode with no device: the released data line reads back ones
        @(posedge mclk);
        serial_mode <= 1'b1;
        ctl(8'hE0);
        poll();
        check(rd_now[23:16], 8'hFF);
        wr(8'h40, 4'h8, {8'hC0, 24'h0});
        @(posedge mclk);
        #1;
        check(rd_now[31], 0);
        summarize();
    end
endmodule // tb
bind nv_memory_access_port nv_port_chk #(.SCL_DIV(SCL_DIV)) u_nv_port_chk (.mclk(mclk),
    .rst(rst), .serial_mode(serial_mode), .host_wr(host_wr), .host_addr(host_addr),
    .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .local_rdata(local_rdata), .rom_req(rom_req), .rom_ack(rom_ack),
    .parallel_mem_address_bus(parallel_mem_address_bus),
    .parallel_mem_data_bus_oe(parallel_mem_data_bus_oe),
    .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
    .scl(scl), .sda_oe(sda_oe));
`default_nettype wire
